/* File: flash_suspend_cfg.svh */
`ifndef FLASH_SUSPEND_CFG_SVH
`define FLASH_SUSPEND_CFG_SVH

// serial opcodes
`define SUSPEND_OPCODE      8'hb0
`define RESUME_OPCODE       8'hd0

// system clock and pause/resume times
`define CLK_FREQ_MHZ        20
`define SUSPEND_LATENCY_US  10
`define RESUME_LATENCY_US   10
`define SUSPEND_LATENCY_CYC (`SUSPEND_LATENCY_US * `CLK_FREQ_MHZ)
`define RESUME_LATENCY_CYC  (`RESUME_LATENCY_US * `CLK_FREQ_MHZ)

// array geometry: 64 sectors of 64KB, page index within the array
`define SECTOR_W            6
`define PAGE_W              13
`define LATENCY_CNT_W       16

`endif

/* File: flash_suspend_pkg.sv */
`include "flash_suspend_cfg.svh"

package flash_suspend_pkg;

    // command classes as sorted by the device's opcode decoder
    typedef enum logic [3:0] {
        CMD_READ_ARRAY   = 4'h0,
        CMD_READ_BUF1    = 4'h1,
        CMD_READ_BUF2    = 4'h2,
        CMD_BUF1_ACCESS  = 4'h3,
        CMD_BUF2_ACCESS  = 4'h4,
        CMD_PROG_NOERASE = 4'h5,
        CMD_PROG_ERASE   = 4'h6,
        CMD_ERASE        = 4'h7,
        CMD_PROT_MODIFY  = 4'h8,
        CMD_PROT_READ    = 4'h9,
        CMD_POWER_DOWN   = 4'ha,
        CMD_REG_READ     = 4'hb,
        CMD_RESET        = 4'hc,
        CMD_OTHER        = 4'hd
    } cmd_class_t;

    typedef enum logic [1:0] {
        OP_PROG_BUF1 = 2'h0,
        OP_PROG_BUF2 = 2'h1,
        OP_ERASE     = 2'h2
    } op_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE       = 3'b001,
        ST_SUSPENDING = 3'b010,
        ST_RESUMING   = 3'b100
    } susp_state_t;

    // operation currently owned by the program/erase engine
    typedef struct packed {
        logic                   valid;
        op_kind_t               kind;
        logic                   pageLevel;
        logic [`SECTOR_W-1:0]   sector;
        logic [`PAGE_W-1:0]     page;
    } run_op_t;

    // decoded command offered for admission
    typedef struct packed {
        logic                   valid;
        cmd_class_t             cls;
        logic [`SECTOR_W-1:0]   sector;
    } cmd_req_t;

    // array read in progress, current address counter sector
    typedef struct packed {
        logic                   active;
        logic [`SECTOR_W-1:0]   sector;
    } read_req_t;

    // region left undefined by a reset during suspension
    typedef struct packed {
        logic                   valid;
        logic                   isPage;
        logic [`SECTOR_W-1:0]   sector;
        logic [`PAGE_W-1:0]     page;
    } undef_t;

endpackage : flash_suspend_pkg

/* File: opcode_rx.sv */
`timescale 1ns/10ps

module opcode_rx (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       sclkPin,
    input  wire logic       csPinN,
    input  wire logic       mosiPin,
    output logic [7:0]      opcode,
    output logic            opcodeDone,
    output logic            csRise
);

    logic       sclkMeta, sclkSync, sclkPrev;
    logic       csMetaN, csSyncN, csPrevN;
    logic       mosiMeta, mosiSync;
    logic [7:0] shift_reg;
    logic [2:0] bitCnt_reg;
    logic       gotByte_reg;
    logic       opcodeDone_reg;
    logic       csRise_reg;

    // pins cross in through two flops each
    always_ff @(posedge clk) begin
        if (reset) begin
            sclkMeta <= 1'b0;
            sclkSync <= 1'b0;
            sclkPrev <= 1'b0;
            csMetaN  <= 1'b1;
            csSyncN  <= 1'b1;
            csPrevN  <= 1'b1;
            mosiMeta <= 1'b0;
            mosiSync <= 1'b0;
        end else begin
            sclkMeta <= sclkPin;
            sclkSync <= sclkMeta;
            sclkPrev <= sclkSync;
            csMetaN  <= csPinN;
            csSyncN  <= csMetaN;
            csPrevN  <= csSyncN;
            mosiMeta <= mosiPin;
            mosiSync <= mosiMeta;
        end
    end

    // first byte only; later bytes in the frame never reach the shifter
    always_ff @(posedge clk) begin
        if (reset || csSyncN) begin
            shift_reg      <= 8'h00;
            bitCnt_reg     <= 3'h0;
            gotByte_reg    <= 1'b0;
            opcodeDone_reg <= 1'b0;
        end else begin
            opcodeDone_reg <= 1'b0;
            if (sclkSync && !sclkPrev && !gotByte_reg) begin
                shift_reg  <= {shift_reg[6:0], mosiSync};
                bitCnt_reg <= bitCnt_reg + 3'h1;
                if (bitCnt_reg == 3'h7) begin
                    gotByte_reg    <= 1'b1;
                    opcodeDone_reg <= 1'b1;
                end
            end
        end
    end

    // end of frame, one pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            csRise_reg <= 1'b0;
        end else begin
            csRise_reg <= csSyncN && !csPrevN;
        end
    end

    assign opcode     = shift_reg;
    assign opcodeDone = opcodeDone_reg;
    assign csRise     = csRise_reg;

endmodule : opcode_rx

/* File: flash_suspend_ctrl.sv */
`timescale 1ns/10ps
`include "flash_suspend_cfg.svh"

// Function
// - suspend is opcode b0, extra bytes ignored
// - halt running operation within suspend latency
// - set the flag matching the paused operation
// - report ready once operation is paused
// - suspension tied to one 64KB sector
// - host must not read suspended sector
// - streaming read undefined inside suspended sector
// - program into erase-suspended sector aborts
// - program elsewhere allowed, may suspend too
// - reset cancels erase suspend, sector undefined
// - reset during page suspend: only page undefined
// - array and buffer reads always accepted
// - suspended buffer refuses write, transfer, compare
// - program without erase only during erase suspend
// - erase and erase-programs always refused
// - protection changes refused, protection reads allowed
// - power-down entry and exit refused
// - status, config, id reads and reset allowed
// - resume opcode d0 clears flag, shows busy
// - dual suspend resumes the program first
// - suspend ignored while resume takes effect
module flash_suspend_ctrl #(
    parameter int SUSPEND_CYC = `SUSPEND_LATENCY_CYC,
    parameter int RESUME_CYC  = `RESUME_LATENCY_CYC
) (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         sclkPin,
    input  wire logic                         csPinN,
    input  wire logic                         mosiPin,
    input  wire logic                         resetPinN,
    input  wire flash_suspend_pkg::run_op_t   runOp,
    input  wire flash_suspend_pkg::cmd_req_t  cmdReq,
    input  wire flash_suspend_pkg::read_req_t readReq,
    output logic                              progHold,
    output logic                              eraseHold,
    output logic                              progSuspendBufOneFlag,
    output logic                              progSuspendBufTwoFlag,
    output logic                              eraseSuspendFlag,
    output logic                              readyFlag,
    output logic                              cmdAccept,
    output logic                              cmdRefuse,
    output logic                              progAbort,
    output logic                              readUndefined,
    output flash_suspend_pkg::undef_t         undefRegion
);

    // flag lands one edge after the count runs out
    localparam int SUSP_MAX = SUSPEND_CYC + 1;
    localparam int RES_MAX  = RESUME_CYC;

    logic [7:0]                    opcode;
    logic                          opcodeDone;
    logic                          csRise;
    logic                          rstMeta, rstSyncN;
    logic                          pendSusp_reg, pendRes_reg;
    flash_suspend_pkg::susp_state_t state_reg;
    logic [`LATENCY_CNT_W-1:0]     cnt_reg;
    flash_suspend_pkg::op_kind_t   suspKind_reg;
    logic                          resProg_reg;
    logic                          progHold_reg, eraseHold_reg;
    logic                          ps1_reg, ps2_reg, es_reg;
    logic [`SECTOR_W-1:0]          esSector_reg, progSector_reg;
    logic [`PAGE_W-1:0]            esPage_reg, progPage_reg;
    logic                          esPageLevel_reg;
    logic                          ready_reg;
    logic                          accept_reg, refuse_reg, abort_reg;
    logic                          readUndef_reg;
    flash_suspend_pkg::undef_t     undef_reg;
    logic                          anyReset, runHeld, suspGo, resGo;
    logic                          cmdOk, progIntoEs, anyFlag;

    opcode_rx u_rx (
        .clk        (clk),
        .reset      (reset),
        .sclkPin    (sclkPin),
        .csPinN     (csPinN),
        .mosiPin    (mosiPin),
        .opcode     (opcode),
        .opcodeDone (opcodeDone),
        .csRise     (csRise)
    );

    // admission table per suspend state; no flags means no restriction
    function automatic logic classAllowed(
        input flash_suspend_pkg::cmd_class_t cls,
        input logic ps1,
        input logic ps2,
        input logic es
    );
        logic ok;
        ok = 1'b1;
        if (ps1 || ps2 || es) begin
            case (cls)
                flash_suspend_pkg::CMD_BUF1_ACCESS:  ok = !ps1;
                flash_suspend_pkg::CMD_BUF2_ACCESS:  ok = !ps2;
                flash_suspend_pkg::CMD_PROG_NOERASE:
                    ok = es && !ps1 && !ps2;
                flash_suspend_pkg::CMD_PROG_ERASE:   ok = 1'b0;
                flash_suspend_pkg::CMD_ERASE:        ok = 1'b0;
                flash_suspend_pkg::CMD_PROT_MODIFY:  ok = 1'b0;
                flash_suspend_pkg::CMD_POWER_DOWN:   ok = 1'b0;
                default:                             ok = 1'b1;
            endcase
        end
        return ok;
    endfunction : classAllowed

    // is the engine's current operation one we are holding
    function automatic logic isHeld(
        input flash_suspend_pkg::op_kind_t kind,
        input logic pHold,
        input logic eHold
    );
        return (kind == flash_suspend_pkg::OP_ERASE) ? eHold : pHold;
    endfunction : isHeld

    // reset pin is asynchronous to clk
    always_ff @(posedge clk) begin
        if (reset) begin
            rstMeta  <= 1'b1;
            rstSyncN <= 1'b1;
        end else begin
            rstMeta  <= resetPinN;
            rstSyncN <= rstMeta;
        end
    end

    assign anyReset = !rstSyncN ||
        (cmdReq.valid && cmdReq.cls == flash_suspend_pkg::CMD_RESET);
    assign runHeld  = isHeld(runOp.kind, progHold_reg, eraseHold_reg);
    assign anyFlag  = ps1_reg || ps2_reg || es_reg;
    // suspend only hits an operation that is actually running
    assign suspGo   = csRise && pendSusp_reg && runOp.valid && !runHeld &&
                      state_reg == flash_suspend_pkg::ST_IDLE;
    assign resGo    = csRise && pendRes_reg && anyFlag &&
                      state_reg == flash_suspend_pkg::ST_IDLE;
    assign cmdOk    = classAllowed(cmdReq.cls, ps1_reg, ps2_reg, es_reg);
    assign progIntoEs = es_reg && cmdReq.sector == esSector_reg &&
        (cmdReq.cls == flash_suspend_pkg::CMD_PROG_NOERASE ||
         cmdReq.cls == flash_suspend_pkg::CMD_PROG_ERASE);

    // opcode acts only when the frame closes
    always_ff @(posedge clk) begin
        if (reset || csRise) begin
            pendSusp_reg <= 1'b0;
            pendRes_reg  <= 1'b0;
        end else if (opcodeDone) begin
            pendSusp_reg <= opcode == `SUSPEND_OPCODE;
            pendRes_reg  <= opcode == `RESUME_OPCODE;
        end
    end

    // latency sequencer
    always_ff @(posedge clk) begin
        if (reset || anyReset) begin
            state_reg    <= flash_suspend_pkg::ST_IDLE;
            cnt_reg      <= '0;
            suspKind_reg <= flash_suspend_pkg::OP_ERASE;
            resProg_reg  <= 1'b0;
        end else begin
            case (state_reg)
                flash_suspend_pkg::ST_IDLE: begin
                    if (suspGo) begin
                        state_reg    <= flash_suspend_pkg::ST_SUSPENDING;
                        cnt_reg      <= `LATENCY_CNT_W'(SUSPEND_CYC - 1);
                        suspKind_reg <= runOp.kind;
                    end else if (resGo) begin
                        state_reg   <= flash_suspend_pkg::ST_RESUMING;
                        cnt_reg     <= `LATENCY_CNT_W'(RESUME_CYC - 1);
                        resProg_reg <= ps1_reg || ps2_reg;
                    end
                end
                flash_suspend_pkg::ST_SUSPENDING: begin
                    if (cnt_reg == '0) begin
                        state_reg <= flash_suspend_pkg::ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - `LATENCY_CNT_W'(1);
                    end
                end
                flash_suspend_pkg::ST_RESUMING: begin
                    if (cnt_reg == '0) begin
                        state_reg <= flash_suspend_pkg::ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - `LATENCY_CNT_W'(1);
                    end
                end
                default: state_reg <= flash_suspend_pkg::ST_IDLE;
            endcase
        end
    end

    // engine holds: freeze at once, release when the resume completes
    always_ff @(posedge clk) begin
        if (reset || anyReset) begin
            progHold_reg  <= 1'b0;
            eraseHold_reg <= 1'b0;
        end else if (suspGo) begin
            if (runOp.kind == flash_suspend_pkg::OP_ERASE) begin
                eraseHold_reg <= 1'b1;
            end else begin
                progHold_reg <= 1'b1;
            end
        end else if (state_reg == flash_suspend_pkg::ST_RESUMING &&
                     cnt_reg == '0) begin
            if (resProg_reg) begin
                progHold_reg <= 1'b0;
            end else begin
                eraseHold_reg <= 1'b0;
            end
        end
    end

    // suspend flags: set as the suspend latency runs out, cleared on resume or reset
    always_ff @(posedge clk) begin
        if (reset || anyReset) begin
            ps1_reg <= 1'b0;
            ps2_reg <= 1'b0;
            es_reg  <= 1'b0;
        end else if (state_reg == flash_suspend_pkg::ST_SUSPENDING &&
                     cnt_reg == '0) begin
            case (suspKind_reg)
                flash_suspend_pkg::OP_PROG_BUF1: ps1_reg <= 1'b1;
                flash_suspend_pkg::OP_PROG_BUF2: ps2_reg <= 1'b1;
                default:                         es_reg  <= 1'b1;
            endcase
        end else if (state_reg == flash_suspend_pkg::ST_RESUMING &&
                     cnt_reg == '0) begin
            if (resProg_reg) begin
                ps1_reg <= 1'b0;
                ps2_reg <= 1'b0;
            end else begin
                es_reg <= 1'b0;
            end
        end
    end

    // location of each paused operation
    always_ff @(posedge clk) begin
        if (reset) begin
            esSector_reg    <= '0;
            esPage_reg      <= '0;
            esPageLevel_reg <= 1'b0;
            progSector_reg  <= '0;
            progPage_reg    <= '0;
        end else if (suspGo) begin
            if (runOp.kind == flash_suspend_pkg::OP_ERASE) begin
                esSector_reg    <= runOp.sector;
                esPage_reg      <= runOp.page;
                esPageLevel_reg <= runOp.pageLevel;
            end else begin
                progSector_reg <= runOp.sector;
                progPage_reg   <= runOp.page;
            end
        end
    end

    // ready while nothing unheld runs and no latency window is open
    always_ff @(posedge clk) begin
        if (reset) begin
            ready_reg <= 1'b1;
        end else begin
            ready_reg <= state_reg == flash_suspend_pkg::ST_IDLE &&
                         !(runOp.valid && !runHeld);
        end
    end

    // admission verdicts; a refused command is only reported, never passed
    always_ff @(posedge clk) begin
        if (reset) begin
            accept_reg <= 1'b0;
            refuse_reg <= 1'b0;
            abort_reg  <= 1'b0;
        end else begin
            accept_reg <= cmdReq.valid && cmdOk && !progIntoEs;
            refuse_reg <= cmdReq.valid && !cmdOk;
            abort_reg  <= cmdReq.valid && cmdOk && progIntoEs;
        end
    end

    // a streaming read turns to garbage only while inside a paused sector
    always_ff @(posedge clk) begin
        if (reset) begin
            readUndef_reg <= 1'b0;
        end else begin
            readUndef_reg <= readReq.active &&
                ((es_reg && readReq.sector == esSector_reg) ||
                 ((ps1_reg || ps2_reg) &&
                  readReq.sector == progSector_reg));
        end
    end

    // damage report on reset; program page wins the single report slot
    always_ff @(posedge clk) begin
        if (reset) begin
            undef_reg <= '0;
        end else begin
            undef_reg.valid <= anyReset && anyFlag;
            if (ps1_reg || ps2_reg) begin
                undef_reg.isPage <= 1'b1;
                undef_reg.sector <= progSector_reg;
                undef_reg.page   <= progPage_reg;
            end else begin
                undef_reg.isPage <= esPageLevel_reg;
                undef_reg.sector <= esSector_reg;
                undef_reg.page   <= esPage_reg;
            end
        end
    end

    assign progHold              = progHold_reg;
    assign eraseHold             = eraseHold_reg;
    assign progSuspendBufOneFlag = ps1_reg;
    assign progSuspendBufTwoFlag = ps2_reg;
    assign eraseSuspendFlag      = es_reg;
    assign readyFlag             = ready_reg;
    assign cmdAccept             = accept_reg;
    assign cmdRefuse             = refuse_reg;
    assign progAbort             = abort_reg;
    assign readUndefined         = readUndef_reg;
    assign undefRegion           = undef_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_suspend_latency: assert property (
        suspGo && !anyReset |-> ##[1:SUSP_MAX] anyFlag && !$past(anyFlag)
            or ##[1:SUSP_MAX] $changed({ps1_reg, ps2_reg, es_reg})
    ) else $error("suspension not reached within latency");

    a_flag_kind: assert property (
        state_reg == flash_suspend_pkg::ST_SUSPENDING && cnt_reg == '0 &&
        suspKind_reg == flash_suspend_pkg::OP_ERASE && !anyReset
        |=> es_reg
    ) else $error("erase suspend flag not set");

    a_ready_paused: assert property (
        $fell(state_reg == flash_suspend_pkg::ST_SUSPENDING) && !anyReset &&
        !(runOp.valid && !runHeld) |=> readyFlag
    ) else $error("ready not shown after suspension");

    a_buf_refuse: assert property (
        cmdReq.valid && ps1_reg &&
        cmdReq.cls == flash_suspend_pkg::CMD_BUF1_ACCESS
        |=> cmdRefuse && !cmdAccept
    ) else $error("suspended buffer access not refused");

    a_noerase_prog: assert property (
        cmdReq.valid && (ps1_reg || ps2_reg) &&
        cmdReq.cls == flash_suspend_pkg::CMD_PROG_NOERASE |=> cmdRefuse
    ) else $error("program without erase accepted in program suspend");

    a_always_refused: assert property (
        cmdReq.valid && anyFlag &&
        (cmdReq.cls == flash_suspend_pkg::CMD_ERASE ||
         cmdReq.cls == flash_suspend_pkg::CMD_PROT_MODIFY ||
         cmdReq.cls == flash_suspend_pkg::CMD_POWER_DOWN)
        |=> cmdRefuse && !cmdAccept && !progAbort
    ) else $error("forbidden command accepted while suspended");

    a_reads_allowed: assert property (
        cmdReq.valid && (cmdReq.cls == flash_suspend_pkg::CMD_READ_ARRAY ||
                         cmdReq.cls == flash_suspend_pkg::CMD_REG_READ)
        |=> cmdAccept && !cmdRefuse
    ) else $error("read refused");

    a_prog_abort: assert property (
        cmdReq.valid && es_reg && cmdReq.sector == esSector_reg &&
        cmdReq.cls == flash_suspend_pkg::CMD_PROG_NOERASE && !ps1_reg &&
        !ps2_reg |=> progAbort && !cmdAccept
    ) else $error("program into erase-suspended sector not aborted");

    a_reset_cancel: assert property (
        anyReset && es_reg |=> !eraseSuspendFlag && undefRegion.valid
    ) else $error("reset did not cancel erase suspend");

    a_resume_order: assert property (
        resGo && es_reg && (ps1_reg || ps2_reg) && !anyReset
        |=> (eraseHold && es_reg) [*8]
    ) else $error("erase resumed before program");

    a_resume_ignore: assert property (
        state_reg == flash_suspend_pkg::ST_RESUMING && !anyReset
        |=> state_reg != flash_suspend_pkg::ST_SUSPENDING
    ) else $error("suspend taken during resume");

    a_resume_clear: assert property (
        resGo && !anyReset |-> ##[1:RES_MAX] !readyFlag
    ) else $error("resume did not show busy");

    a_read_undef: assert property (
        readReq.active && es_reg && readReq.sector == esSector_reg
        |=> readUndefined
    ) else $error("read in suspended sector not flagged");

endmodule : flash_suspend_ctrl

/* File: spi_host_model.sv */
`timescale 1ns/10ps

// serial host: mode 0, clock still outside frames
module spi_host_model (
    input  wire logic       go,
    input  wire logic [7:0] data,
    output logic            sclkPin,
    output logic            csPinN,
    output logic            mosiPin,
    output logic            busy
);
    initial begin
        sclkPin = 1'b0;
        csPinN = 1'b1;
        mosiPin = 1'b0;
        busy = 1'b0;
    end
    // opcode then a junk byte, which the device must drop
    always @(posedge go) begin
        #37 busy = 1'b1;
        csPinN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosiPin = (i > 7) ? data[i-8] : ~data[i];
            #200 sclkPin = 1'b1;
            #200 sclkPin = 1'b0;
        end
        #100 csPinN = 1'b1;
        mosiPin = ~mosiPin; // released line shows no stale bit
        busy = 1'b0;
    end
endmodule : spi_host_model

/* File: testbench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end

module testbench;
    logic clk = 1'b0, reset = 1'b1, go = 1'b0, resetPinN = 1'b1;
    logic [7:0] data = 8'h00;
    logic sclkPin, csPinN, mosiPin, busy, progHold, eraseHold, readyFlag;
    logic progSuspendBufOneFlag, progSuspendBufTwoFlag, eraseSuspendFlag;
    logic cmdAccept, cmdRefuse, progAbort, readUndefined, p1, p2, e;
    logic [7:0] seen = '0;
    logic [5:0] esec = 6'h00;
    logic [31:0] seed = 32'h1919;
    int errors = 0, checked = 0, cycles = 0;
    flash_suspend_pkg::run_op_t runOp = '0;
    flash_suspend_pkg::cmd_req_t cmdReq = '0;
    flash_suspend_pkg::read_req_t readReq = '0;
    flash_suspend_pkg::undef_t undefRegion;

    always #25 clk = ~clk;
    spi_host_model i_spi_host_model (.go, .data, .sclkPin, .csPinN,
        .mosiPin, .busy);
    flash_suspend_ctrl #(.SUSPEND_CYC(4), .RESUME_CYC(4))
        i_flash_suspend_ctrl (.clk, .reset, .sclkPin, .csPinN, .mosiPin,
        .resetPinN, .runOp, .cmdReq, .readReq, .progHold, .eraseHold,
        .progSuspendBufOneFlag, .progSuspendBufTwoFlag, .eraseSuspendFlag,
        .readyFlag, .cmdAccept, .cmdRefuse, .progAbort, .readUndefined,
        .undefRegion);
    // sticky capture, the pulse is too short to poll
    always @(posedge clk) begin
        cycles++;
        if (undefRegion.valid)
            seen <= {1'b1, undefRegion.isPage, undefRegion.sector};
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // verdict {accept, refuse, abort} from the permission table
    function automatic logic [2:0] expv(input int c, input logic [5:0] s);
        logic ok;
        case (c)
            flash_suspend_pkg::CMD_BUF1_ACCESS:  ok = !p1;
            flash_suspend_pkg::CMD_BUF2_ACCESS:  ok = !p2;
            flash_suspend_pkg::CMD_PROG_NOERASE: ok = !(p1 | p2);
            flash_suspend_pkg::CMD_PROG_ERASE, flash_suspend_pkg::CMD_ERASE,
            flash_suspend_pkg::CMD_PROT_MODIFY,
            flash_suspend_pkg::CMD_POWER_DOWN: ok = 1'b0;
            default: ok = 1'b1;
        endcase
        if (ok && e && s == esec && c == flash_suspend_pkg::CMD_PROG_NOERASE)
            return 3'b001;
        return ok ? 3'b100 : 3'b010;
    endfunction : expv
    task automatic frame(input logic [7:0] op);
        data <= op;
        go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        wait (busy);
        wait (!busy);
        repeat (12) @(posedge clk);
    endtask : frame
    // classes 0 to 11 once on the suspended sector, then random ones among them
    task automatic burst(input int n);
        logic [31:0] r;
        logic [5:0] s;
        int c;
        for (int i = 0; i < n; i++) begin
            r = rnd();
            c = (i < 12) ? i : int'(r[3:0]) % 12;
            s = (i < 12 || r[10]) ? esec : r[9:4];
            cmdReq <= {1'b1, 4'(c), s};
            @(posedge clk) cmdReq <= '0;
            @(negedge clk); // verdict stands for this one cycle only
            `CHK({cmdAccept, cmdRefuse, progAbort}, expv(c, s))
            @(posedge clk);
        end
    endtask : burst
    task automatic flags(input logic [3:0] x);
        `CHK({progSuspendBufOneFlag, progSuspendBufTwoFlag, eraseSuspendFlag,
            readyFlag}, x)
    endtask : flags
    task automatic results();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        {p1, p2, e, esec} = {3'b100, 6'd5};
        runOp <= {1'b1, flash_suspend_pkg::OP_PROG_BUF1, 1'b0, esec, 13'h0a0};
        frame(8'hb0);
        `CHK(progHold, 1'b1)
        flags(4'b1001);
        burst(40);
        readReq <= {1'b1, esec};
        repeat (3) @(posedge clk);
        `CHK(readUndefined, 1'b1)
        readReq <= {1'b1, 6'd6};
        repeat (3) @(posedge clk);
        `CHK(readUndefined, 1'b0)
        readReq <= '0;
        frame(8'hd0);
        flags(4'b0000);
        $display("program suspend test done");
        {p1, e, esec} = {2'b01, 6'd9};
        runOp <= {1'b1, flash_suspend_pkg::OP_ERASE, 1'b0, esec, 13'h0000};
        frame(8'hb0);
        `CHK(eraseHold, 1'b1)
        flags(4'b0011);
        burst(20);
        p2 = 1'b1;
        runOp <= {1'b1, flash_suspend_pkg::OP_PROG_BUF2, 1'b0, 6'd3, 13'h0007};
        frame(8'hb0);
        flags(4'b0111);
        burst(30);
        frame(8'hd0);
        flags(4'b0010);
        $display("dual suspend test done");
        resetPinN <= 1'b0;
        runOp <= '0; // the engine drops its work on reset
        repeat (6) @(posedge clk);
        resetPinN <= 1'b1;
        repeat (4) @(posedge clk);
        flags(4'b0001);
        `CHK(seen, {2'b10, 6'd9})
        $display("reset test done");
        results();
    end
endmodule : testbench
